// File: asr_params.svh
// timing counts and field widths for the async sram host controller
// How it works
// RULE1 - the memory holds 4096 nibbles reached by a 12-bit word address, one nibble per access.
// RULE2 - a read returns the nibble as written, with no inversion, and leaves it unchanged.
// RULE3 - one four-pin data bus carries both directions and the host releases it while the memory drives.
// RULE4 - the memory outputs are three-state so only the selected part drives the shared lines.
// RULE5 - the memory keeps its contents with no clock and no refresh, so the host sends none.
// RULE6 - the host may start the write strobe in the same cycle the address becomes valid.
// RULE7 - after select is released the memory floats its outputs within the grade maximum.
// RULE8 - once the write strobe is active the memory floats its outputs within the grade maximum.
// RULE9 - after the write strobe ends with select still low the memory may drive at once.
// RULE10 - the memory holds old read data a grade minimum after the address changes.
// RULE11 - the host holds write data valid a grade minimum before the strobe or select ends.
// RULE12 - the host keeps the write strobe low at least the grade minimum pulse width.
// RULE13 - the host waits at least 0.5 ms after power-up before any access.
// RULE14 - back-to-back reads run at the access period with no recovery gap; the code spaces them 23 cycles apart, access plus synchroniser.
// RULE15 - select and strobe low writes the pin nibble; select low, strobe high drives the nibble out.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
`define ASR_ADDR_W 12
`define ASR_DATA_W 4
`define ASR_CLK_PS 4000
// slowest grade figures, in picoseconds, except the power-up wait in microseconds
`define ASR_T_RC_PS 70000
`define ASR_T_HZ_PS 30000
`define ASR_T_WZ_PS 30000
`define ASR_T_WP_PS 60000
`define ASR_T_DW_PS 25000
`define ASR_T_WR_PS 5000
`define ASR_T_PWR_US 500
// pin synchroniser delay beyond the access, in cycles
`define ASR_SYNC_CYC 3
`define ASR_RC_CYC ((`ASR_T_RC_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS + 1)
`define ASR_HZ_CYC ((`ASR_T_HZ_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_WZ_CYC ((`ASR_T_WZ_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_WP_CYC ((`ASR_T_WP_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_WR_CYC ((`ASR_T_WR_PS + `ASR_CLK_PS - 1) / `ASR_CLK_PS)
`define ASR_PWR_CYC (`ASR_T_PWR_US * 1000000 / `ASR_CLK_PS)
`endif

// File: asr_pkg.sv
// types for the async sram host controller
package asr_pkg;
    typedef enum logic [5:0] {
        ASR_POWER = 6'h01,
        ASR_IDLE = 6'h02,
        ASR_READ = 6'h04,
        ASR_WRITE = 6'h08,
        ASR_WREC = 6'h10,
        ASR_FLOAT = 6'h20
    } asr_state_type;
endpackage

// File: asr_sync.sv
// three-stage pin synchroniser, change taken once stages two and three agree
`timescale 1ns/1ns
module asr_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    wire agree = (s2_ff == s3_ff);
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (agree) begin
                out_ff <= s3_ff;
            end
        end
    end
    assign dout = out_ff;
endmodule // asr_sync

// File: asr_host.sv
// host controller that drives a 4096 x 4 asynchronous static ram
`timescale 1ns/1ns
`include "asr_params.svh"
module asr_host
    import asr_pkg::*;
#(
    parameter int PWR_CYC = `ASR_PWR_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`ASR_ADDR_W-1:0] req_addr,
    input wire logic [`ASR_DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`ASR_DATA_W-1:0] rsp_rdata,
    output logic [`ASR_ADDR_W-1:0] mem_addr,
    output logic mem_cs_n,
    output logic mem_we_n,
    input wire logic [`ASR_DATA_W-1:0] data_pin_i,
    output logic [`ASR_DATA_W-1:0] data_pin_o,
    output logic data_pin_oe
);
    // read count also covers the pin synchroniser, else stale data
    localparam logic [19:0] RD_CYC = 20'(`ASR_RC_CYC + `ASR_SYNC_CYC);
    localparam logic [19:0] WZ_CYC = 20'(`ASR_WZ_CYC);
    localparam logic [19:0] WP_CYC = 20'(`ASR_WP_CYC);
    localparam logic [19:0] WR_CYC = 20'(`ASR_WR_CYC);
    localparam logic [19:0] HZ_CYC = 20'(`ASR_HZ_CYC);
    localparam logic [19:0] PWR_LAST = 20'(PWR_CYC);

    asr_state_type state_ff;
    asr_state_type nxt_state;
    logic [19:0] cnt_ff;
    logic [19:0] nxt_cnt;
    logic [`ASR_ADDR_W-1:0] addr_ff;
    logic [`ASR_DATA_W-1:0] wdata_ff;
    logic cs_n_ff;
    logic we_n_ff;
    logic oe_ff;
    logic ready_ff;
    logic rvalid_ff;
    logic [`ASR_DATA_W-1:0] rdata_ff;
    logic [`ASR_DATA_W-1:0] pin_sync;

    asr_sync #(.W(`ASR_DATA_W)) u_sync (
        .clk(clk),
        .rst(rst),
        .din(data_pin_i),
        .dout(pin_sync)
    );

    // RULE12 strobe width for a write, access plus sync for a read
    function automatic logic [19:0] load_cnt(input logic wr);
        load_cnt = wr ? WP_CYC : RD_CYC;
    endfunction

    function automatic asr_state_type load_state(input logic wr);
        load_state = wr ? ASR_WRITE : ASR_READ;
    endfunction

    wire cnt_done = (cnt_ff == 20'h0_0000);
    wire take = ready_ff & req_valid;
    wire [19:0] cnt_dec = cnt_done ? cnt_ff : cnt_ff - 20'h0_0001;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_dec;
        case (state_ff)
            // RULE13 power-up wait
            ASR_POWER: begin
                if (cnt_done) begin
                    nxt_state = ASR_IDLE;
                end
            end
            ASR_IDLE: begin
                if (take) begin
                    nxt_state = load_state(req_write);
                    nxt_cnt = load_cnt(req_write);
                end
            end
            ASR_READ: begin
                // RULE14 back-to-back reads
                if (cnt_done) begin
                    if (take) begin
                        // a write here holds oe off until the memory floats
                        nxt_state = load_state(req_write);
                        nxt_cnt = load_cnt(req_write);
                    end else begin
                        nxt_state = ASR_FLOAT;
                        nxt_cnt = HZ_CYC;
                    end
                end
            end
            ASR_WRITE: begin
                if (cnt_done) begin
                    nxt_state = ASR_WREC;
                    nxt_cnt = WR_CYC;
                end
            end
            ASR_WREC: begin
                if (cnt_done) begin
                    nxt_state = ASR_IDLE;
                end
            end
            // RULE7 wait for device release
            ASR_FLOAT: begin
                if (cnt_done) begin
                    nxt_state = ASR_IDLE;
                end
            end
            default: begin
                nxt_state = ASR_IDLE;
                nxt_cnt = 20'h0_0000;
            end
        endcase
    end

    // ready only where a request of either kind is taken
    wire ready_nxt = (nxt_state == ASR_IDLE) ||
        (nxt_state == ASR_READ && nxt_cnt == 20'h0_0000);
    wire go_read = (nxt_state == ASR_READ);
    wire go_write = (nxt_state == ASR_WRITE);
    wire strobe_on = go_write && (nxt_cnt != 20'h0_0000);
    wire read_end = (state_ff == ASR_READ) && cnt_done;
    // RULE15 select and strobe coding
    wire nxt_cs_n = !(go_read || go_write);
    // RULE6 strobe with address
    wire nxt_we_n = !strobe_on;
    // RULE3 drive once memory floated
    // RULE11 data held to strobe end
    wire nxt_oe = strobe_on && (nxt_cnt <= WP_CYC - WZ_CYC);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ASR_POWER;
            // power wait restarts with every reset
            cnt_ff <= PWR_LAST;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_ff <= 12'h000;
        end else if (take) begin
            // RULE1 word address
            addr_ff <= req_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wdata_ff <= 4'h0;
        end else if (take) begin
            wdata_ff <= req_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_ff <= 1'b1;
        end else begin
            cs_n_ff <= nxt_cs_n;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            we_n_ff <= 1'b1;
        end else begin
            we_n_ff <= nxt_we_n;
        end
    end

    // oe drops with the strobe, the memory may drive right after
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= nxt_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= ready_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= read_end;
        end
    end

    // captured on the last read cycle, held until the next read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 4'h0;
        end else if (read_end) begin
            // RULE2 no inversion
            rdata_ff <= pin_sync;
        end
    end

    assign req_ready = ready_ff;
    assign rsp_valid = rvalid_ff;
    assign rsp_rdata = rdata_ff;
    assign mem_addr = addr_ff;
    assign mem_cs_n = cs_n_ff;
    assign mem_we_n = we_n_ff;
    assign data_pin_o = wdata_ff;
    assign data_pin_oe = oe_ff;
endmodule // asr_host

// File: asr_monitor.sv
// concurrent checks on the sram host controller pins
`timescale 1ns/1ns
`include "asr_params.svh"
module asr_monitor #(
    parameter int PWR_CYC = `ASR_PWR_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [`ASR_ADDR_W-1:0] mem_addr,
    input wire logic mem_cs_n,
    input wire logic mem_we_n,
    input wire logic [`ASR_DATA_W-1:0] data_pin_o,
    input wire logic data_pin_oe
);
    localparam int WP_CYC = `ASR_WP_CYC;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] up_ff;
    logic [7:0] wlow_ff;
    always_ff @(posedge clk) begin
        up_ff <= rst ? '0 : (up_ff < PWR_CYC) ? up_ff + 32'h1 : up_ff;
        wlow_ff <= (rst || mem_we_n) ? '0 : wlow_ff + 8'h1;
    end
    // host holds off while the memory floats, then drives to strobe end
    sequence s_wr_drive;
        (!data_pin_oe)[*8] ##1
            (!mem_we_n && data_pin_oe && $stable(data_pin_o))[*7];
    endsequence
    sequence s_rd_answer;
        !mem_cs_n && mem_we_n ##[1:40] rsp_valid;
    endsequence
    a_power_wait: assert property (!mem_cs_n |-> up_ff >= PWR_CYC)
        else $error("access before power wait");
    a_strobe_select: assert property (!mem_we_n |-> !mem_cs_n)
        else $error("strobe without select");
    a_release_bus: assert property (!mem_cs_n && mem_we_n |-> !data_pin_oe)
        else $error("host drives during read");
    a_write_drive: assert property ($fell(mem_we_n) |-> s_wr_drive)
        else $error("write data not driven");
    a_write_start: assert property (req_valid && req_ready && req_write
        |=> !mem_we_n && !mem_cs_n)
        else $error("strobe not with address");
    a_addr_hold: assert property (!mem_we_n && !$past(mem_we_n)
        |-> $stable(mem_addr))
        else $error("address moved in strobe");
    a_pulse_width: assert property ($rose(mem_we_n) |-> wlow_ff >= WP_CYC)
        else $error("write pulse short");
    a_data_setup: assert property ($rose(mem_we_n) |-> $past(data_pin_oe, 7)
        && $past(data_pin_o, 7) == $past(data_pin_o))
        else $error("write data setup short");
    a_read_answer: assert property (req_valid && req_ready && !req_write
        |=> s_rd_answer)
        else $error("read not answered");
endmodule // asr_monitor
bind asr_host asr_monitor #(.PWR_CYC(PWR_CYC)) u_mon (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
    .mem_we_n(mem_we_n), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));

// File: asr_sram_model.sv
// behavioural 4096 x 4 asynchronous static ram
`timescale 1ns/1ns
module asr_sram_model #(
    parameter int T_ACC = 70,
    parameter int T_OH = 5
) (
    input wire logic [11:0] mem_addr,
    input wire logic mem_cs_n,
    input wire logic mem_we_n,
    input wire logic [3:0] bus_in,
    output logic [3:0] mem_dq
);
    // static store, no clock or refresh
    logic [3:0] mem_arr [4096];
    logic rd_en;
    assign rd_en = !mem_cs_n && mem_we_n;
    // latch write while both strobes low
    always @* if (!mem_cs_n && !mem_we_n) mem_arr[mem_addr] = bus_in;
    always @(mem_addr or rd_en) begin
        mem_dq <= #(T_OH) ~mem_dq;
        if (rd_en) mem_dq <= #(T_ACC) mem_arr[mem_addr];
    end
    initial mem_dq = 4'h5;
endmodule // asr_sram_model

// File: async_sram_4k_by_4_tb.sv
// self-checking bench for the sram host controller
`timescale 1ns/1ns
module async_sram_4k_by_4_tb;
    logic clk, rst, req_valid, req_write, req_ready, rsp_valid;
    logic mem_cs_n, mem_we_n, data_pin_oe;
    logic [11:0] req_addr, mem_addr, a;
    logic [3:0] req_wdata, rsp_rdata, data_pin_o, mem_dq, data_pin_i, d;
    logic [3:0] ref_mem [logic [11:0]];
    logic [3:0] exp_q [$];
    logic [11:0] used [$];
    int err_total = 0;
    int compares = 0;
    asr_host #(.PWR_CYC(20)) u_dut (.clk(clk), .rst(rst),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
        .mem_we_n(mem_we_n), .data_pin_i(data_pin_i),
        .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));
    asr_sram_model u_mem (.mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
        .mem_we_n(mem_we_n), .bus_in(data_pin_i), .mem_dq(mem_dq));
    // shared pins: host level wins only while it drives
    // small delay so the model sees the strobe end before the release
    assign #1 data_pin_i = data_pin_oe ? data_pin_o : mem_dq;
    task automatic final_report;
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk4(string nm, logic [3:0] e, logic [3:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic access(logic w, logic [11:0] ad, logic [3:0] dt);
        int n;
        req_valid = 1;
        req_write = w;
        req_addr = ad;
        req_wdata = dt;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n > 300) begin
                err_total++;
                final_report;
            end
        end while (req_ready !== 1'b1);
        if (w) ref_mem[ad] = dt;
        else exp_q.push_back(ref_mem[ad]);
        @(posedge clk);
        #1;
    endtask
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk4("spurious rsp", 4'h0, 4'hf);
            else chk4("rsp_rdata", exp_q.pop_front(), rsp_rdata);
        end
    end
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst = 1;
        req_valid = 0;
        req_write = 0;
        req_addr = 12'h000;
        req_wdata = 4'h0;
        void'($urandom(32342));
        repeat (8) @(posedge clk);
        #1 rst = 0;
        for (int i = 0; i < 16; i++) begin
            a = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            d = 4'($urandom);
            used.push_back(a);
            access(1'b1, a, d);
        end
        access(1'b1, 12'hfff, ~ref_mem[12'hfff]);
        foreach (used[j]) access(1'b0, used[j], 4'h0);
        access(1'b1, 12'h000, ~ref_mem[12'h000]);
        access(1'b0, 12'h000, 4'h0);
        req_valid = 0;
        for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk);
        if (exp_q.size() > 0) err_total++;
        final_report;
    end
endmodule // async_sram_4k_by_4_tb
